// *** common/irs_consts.svh ***
`ifndef IRS_CONSTS_SVH
`define IRS_CONSTS_SVH

// Own seven-bit slave address, 0011 000
`define IRS_DEV_ADDR   7'h18
// General-call address byte
`define IRS_GC_ADDR    8'h00
// General-call enable: page 0 register 34, bit D5
`define IRS_GC_REG     7'h22
`define IRS_GC_BIT     5
// Page select register, present on every page
`define IRS_PAGE_REG   7'h00
// Page that holds the stored control registers
`define IRS_PAGE0      8'h00
// Reset values
`define IRS_PAGE_RST   8'h00
`define IRS_REG_RST    8'h00
`define IRS_CNT_RST    4'h0
// Registers per page
`define IRS_REG_NUM    128
// Bit slot counts within a byte frame
`define IRS_BIT_LAST   4'h7
`define IRS_BIT_ACK    4'h8
// Read value of unbacked pages
`define IRS_RD_NONE    8'h00

`endif

// *** common/irs_pkg.sv ***
`default_nettype none
package irs_pkg;

    // Protocol states of the slave
    typedef enum logic [2:0] {
        S_IDLE,     // Bus idle, waiting for start
        S_ADDR,     // Receiving address byte
        S_WPTR,     // Receiving register pointer
        S_WDATA,    // Receiving register data
        S_READ,     // Sending register data
        S_SKIP      // Not addressed or master ended read
    } irs_state_t;

    // Sampled serial line pair
    typedef struct packed {
        logic scl;  // Clock line level
        logic sda;  // Data line level
    } irs_pins_t;

endpackage : irs_pkg
`default_nettype wire

// *** verilog/irs_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "irs_consts.svh"
module irs_slave
    import irs_pkg::*;
(
    input  wire logic clk,          // Core clock, 125 MHz
    input  wire logic rst_b,        // Asynchronous reset, active low
    input  wire logic scl_clk,      // Serial clock pin used as link clock
    input  wire logic scl_i,        // Serial clock pin level
    input  wire logic sda_i,        // Serial data pin level
    output var  logic scl_o,        // Serial clock drive value
    output var  logic scl_oe_b,     // Serial clock enable, low drives
    output var  logic sda_o,        // Serial data drive value
    output var  logic sda_oe_b,     // Serial data enable, low drives
    output var  logic [7:0] page,   // Selected register page
    output var  logic gc_en,        // General-call response enabled
    output var  logic busy          // Transfer in progress
);
    ////////////////////////////////////////////////////////////////////////////
    // Link domain: bit capture on the serial clock
    logic       lk_bit_q;           // Data bit captured at clock high
    logic       lk_bit_d;           // Next captured bit
    logic       lk_tog_q;           // Flips once per captured bit
    logic       lk_tog_d;           // Next toggle value
    // Capture each bit on the clock rising edge
    // receiver samples at clock high
    always_comb begin
        lk_bit_d = sda_i;
        lk_tog_d = ~lk_tog_q;
    end
    // Link registers
    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_bit_q <= 1'b0;
            lk_tog_q <= 1'b0;
        end else begin
            lk_bit_q <= lk_bit_d;
            lk_tog_q <= lk_tog_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the core domain
    irs_pins_t  pin_s1_q;           // Pin synchroniser first stage
    irs_pins_t  pin_s2_q;           // Pin synchroniser second stage
    irs_pins_t  pin_p_q;            // Previous synchronised levels
    logic       tog_s1_q;           // Toggle synchroniser first stage
    logic       tog_s2_q;           // Toggle synchroniser second stage
    logic       tog_s3_q;           // Toggle edge history
    logic       ev;                 // New bit available this cycle
    logic       start_det;          // Start condition seen
    logic       stop_det;           // Stop condition seen
    // Two-stage synchronisers and edge history
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q <= '{scl: 1'b1, sda: 1'b1};
            pin_s2_q <= '{scl: 1'b1, sda: 1'b1};
            pin_p_q  <= '{scl: 1'b1, sda: 1'b1};
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= '{scl: scl_i, sda: sda_i};
            pin_s2_q <= pin_s1_q;
            pin_p_q  <= pin_s2_q;
            tog_s1_q <= lk_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end
    // Captured bit is stable long after its toggle arrives
    assign ev = tog_s2_q ^ tog_s3_q;
    assign start_det = pin_p_q.scl & pin_s2_q.scl & pin_p_q.sda & ~pin_s2_q.sda;
    assign stop_det  = pin_p_q.scl & pin_s2_q.scl & ~pin_p_q.sda & pin_s2_q.sda;
    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] mem_q [`IRS_REG_NUM];   // Page 0 registers
    logic [7:0] mem_d [`IRS_REG_NUM];   // Next register values
    logic       wr_en;                  // Register write strobe
    logic [6:0] wr_idx;                 // Register write index
    logic [7:0] wr_dat;                 // Register write data
    logic [7:0] page_q;                 // Selected page
    logic [7:0] page_d;                 // Next page
    // One storage entry per register
    // eight-bit readable registers
    for (genvar i = 0; i < `IRS_REG_NUM; i++) begin : g_reg
        always_comb begin
            mem_d[i] = (wr_en && wr_idx == 7'(i)) ? wr_dat : mem_q[i];
        end
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                mem_q[i] <= `IRS_REG_RST;
            end else begin
                mem_q[i] <= mem_d[i];
            end
        end
    end
    // Read view of one register in the current page
    function automatic logic [7:0] rd_of(input logic [6:0] idx);
        logic [7:0] v;
        v = `IRS_RD_NONE;
        if (idx == `IRS_PAGE_REG) begin
            v = page_q;
        end else if (page_q == `IRS_PAGE0) begin
            v = mem_q[idx];
        end
        return v;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Protocol engine
    irs_state_t state_q, state_d;       // Protocol state
    logic [3:0] cnt_q, cnt_d;           // Bit slot in byte frame
    logic [7:0] sr_q, sr_d;             // Received bit shifter
    logic [7:0] tx_q, tx_d;             // Transmit shifter
    logic [6:0] ptr_q, ptr_d;           // Register pointer
    logic       rw_q, rw_d;             // Direction bit, 1 reads
    logic       pend_q, pend_d;         // Drive update due at clock low
    logic       dval_q, dval_d;         // Pending value, 1 pulls low
    logic       oe_b_q, oe_b_d;         // Data enable register
    logic       busy_q, busy_d;         // Busy register
    logic       bit_s;                  // Captured bit in core domain
    logic [7:0] byte_in;                // Byte completed by this bit
    logic       own_hit;                // Own address matched
    logic       gc_hit;                 // Enabled general call matched
    assign bit_s   = lk_bit_q;
    assign byte_in = {sr_q[6:0], bit_s};
    assign own_hit = byte_in[7:1] == `IRS_DEV_ADDR;
    assign gc_hit  = byte_in == `IRS_GC_ADDR && mem_q[`IRS_GC_REG][`IRS_GC_BIT];
    // Next-state logic of the slave
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sr_d    = sr_q;
        tx_d    = tx_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        pend_d  = pend_q;
        dval_d  = dval_q;
        oe_b_d  = oe_b_q;
        page_d  = page_q;
        wr_en   = 1'b0;
        wr_idx  = ptr_q;
        wr_dat  = byte_in;
        if (stop_det) begin
            state_d = S_IDLE;
            pend_d  = 1'b0;
            oe_b_d  = 1'b1;
        end else if (start_det) begin
            state_d = S_ADDR;
            cnt_d   = `IRS_CNT_RST;
            pend_d  = 1'b0;
            oe_b_d  = 1'b1;
        end else begin
            // apply drive only while clock low
            if (pend_q && !pin_s2_q.scl) begin
                oe_b_d = ~dval_q;
                pend_d = 1'b0;
            end
            if (ev && state_q != S_IDLE) begin
                cnt_d  = (cnt_q == `IRS_BIT_ACK) ? `IRS_CNT_RST : cnt_q + 4'h1;
                sr_d   = byte_in;
                pend_d = 1'b1;
                dval_d = 1'b0;
                case (state_q)
                    S_ADDR: begin
                        if (cnt_q == `IRS_BIT_LAST) begin
                            if (own_hit || gc_hit) begin
                                dval_d = 1'b1;
                                rw_d   = bit_s;
                            end else begin
                                state_d = S_SKIP;
                            end
                        end else if (cnt_q == `IRS_BIT_ACK) begin
                            if (rw_q) begin
                                state_d = S_READ;
                                tx_d    = rd_of(ptr_q);
                                dval_d  = ~tx_d[7];
                            end else begin
                                state_d = S_WPTR;
                            end
                        end
                    end
                    S_WPTR: begin
                        if (cnt_q == `IRS_BIT_LAST) begin
                            ptr_d  = byte_in[6:0];
                            dval_d = 1'b1;
                        end else if (cnt_q == `IRS_BIT_ACK) begin
                            state_d = S_WDATA;
                        end
                    end
                    S_WDATA: begin
                        if (cnt_q == `IRS_BIT_LAST) begin
                            dval_d = 1'b1;
                            ptr_d  = ptr_q + 7'h01;
                            if (ptr_q == `IRS_PAGE_REG) begin
                                page_d = byte_in;
                            end else if (page_q == `IRS_PAGE0) begin
                                wr_en = 1'b1;
                            end
                        end
                    end
                    S_READ: begin
                        if (cnt_q < `IRS_BIT_LAST) begin
                            tx_d   = {tx_q[6:0], 1'b0};
                            dval_d = ~tx_d[7];
                        end else if (cnt_q == `IRS_BIT_ACK) begin
                            if (!bit_s) begin
                                ptr_d  = ptr_q + 7'h01;
                                tx_d   = rd_of(ptr_d);
                                dval_d = ~tx_d[7];
                            end else begin
                                // no ack from master ends read
                                state_d = S_SKIP;
                            end
                        end
                    end
                    default: begin
                        dval_d = 1'b0;
                    end
                endcase
            end
        end
        busy_d = state_d != S_IDLE;
    end
    // Protocol registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
            cnt_q   <= `IRS_CNT_RST;
            sr_q    <= `IRS_REG_RST;
            tx_q    <= `IRS_REG_RST;
            ptr_q   <= `IRS_PAGE_REG;
            rw_q    <= 1'b0;
            pend_q  <= 1'b0;
            dval_q  <= 1'b0;
            oe_b_q  <= 1'b1;
            busy_q  <= 1'b0;
            page_q  <= `IRS_PAGE_RST;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sr_q    <= sr_d;
            tx_q    <= tx_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            pend_q  <= pend_d;
            dval_q  <= dval_d;
            oe_b_q  <= oe_b_d;
            busy_q  <= busy_d;
            page_q  <= page_d;
        end
    end
    // clock never driven, data only low
    assign scl_o    = 1'b0;
    assign scl_oe_b = 1'b1;
    assign sda_o    = 1'b0;
    assign sda_oe_b = oe_b_q;
    assign page     = page_q;
    assign gc_en    = mem_q[`IRS_GC_REG][`IRS_GC_BIT];
    assign busy     = busy_q;
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    addr_ack_a: assert property (ev && state_q == S_ADDR && cnt_q == `IRS_BIT_LAST
        && own_hit |=> pend_q && dval_q ##[1:200] !sda_oe_b)
        else $error("matched address not acknowledged");
    clk_release_a: assert property (scl_oe_b)
        else $error("serial clock driven");
    data_timing_a: assert property ($changed(sda_oe_b) && !$past(start_det || stop_det)
        |-> !$past(pin_s2_q.scl))
        else $error("data changed while clock high");
    addr_miss_a: assert property (ev && state_q == S_ADDR && cnt_q == `IRS_BIT_LAST
        && !own_hit && !gc_hit |=> state_q == S_SKIP && !dval_q)
        else $error("mismatched address answered");
    stop_idle_a: assert property (stop_det |=> state_q == S_IDLE && sda_oe_b && !busy)
        else $error("stop did not idle");
    restart_a: assert property (start_det && !stop_det |=> state_q == S_ADDR
        && cnt_q == `IRS_CNT_RST && sda_oe_b)
        else $error("start did not restart address");
    gc_gate_a: assert property (ev && state_q == S_ADDR && cnt_q == `IRS_BIT_LAST
        && byte_in == `IRS_GC_ADDR && !gc_en |=> state_q == S_SKIP)
        else $error("general call answered while disabled");
    write_inc_a: assert property (ev && state_q == S_WDATA && cnt_q == `IRS_BIT_LAST
        && !start_det && !stop_det |=> ptr_q == $past(ptr_q) + 7'h01)
        else $error("write pointer not advanced");
    read_inc_a: assert property (ev && state_q == S_READ && cnt_q == `IRS_BIT_ACK
        && !bit_s && !start_det && !stop_det |=> ptr_q == $past(ptr_q) + 7'h01
        && tx_q == rd_of(ptr_q))
        else $error("read did not move to next register");
    page_sel_a: assert property (ev && state_q == S_WDATA && cnt_q == `IRS_BIT_LAST
        && ptr_q == `IRS_PAGE_REG && !start_det && !stop_det |=> page == $past(byte_in))
        else $error("page not selected");
    addr_hit_c: cover property (ev && state_q == S_ADDR && cnt_q == `IRS_BIT_LAST && own_hit);
    burst_wr_c: cover property (ev && state_q == S_WDATA && cnt_q == `IRS_BIT_LAST
        && ptr_q != `IRS_PAGE_REG);
    burst_rd_c: cover property (ev && state_q == S_READ && cnt_q == `IRS_BIT_ACK && !bit_s);
    restart_c: cover property (start_det && state_q == S_WDATA);
endmodule // irs_slave
`default_nettype wire

// *** sim/irs_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// Bus master model on a free 32 ns link tick
module irs_master (
    output var  logic scl_m,  // Clock drive, 1 releases
    output var  logic sda_m,  // Data drive, 1 releases
    input  wire logic sda_w   // Data line level
);
    logic tck;      // Link tick
    int   hp = 7;   // Ticks per clock phase
    // Link tick, phase unrelated to core clock
    initial begin
        tck = 1'b0;
        #3.3;
        forever #16 tck = ~tck;
    end
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // Wait n ticks
    task automatic w(input int n);
        repeat (n) @(posedge tck);
    endtask
    task automatic start();
        sda_m <= 1'b1;
        w(hp);
        scl_m <= 1'b1;
        w(hp);
        sda_m <= 1'b0;
        w(hp);
        scl_m <= 1'b0;
        w(hp);
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        w(hp);
        scl_m <= 1'b1;
        w(hp);
        sda_m <= 1'b1;
        w(hp);
    endtask
    task automatic bit1(input logic b, output logic r);
        sda_m <= b;
        w(hp);
        scl_m <= 1'b1;
        w(hp);
        r = sda_w;
        scl_m <= 1'b0;
        w(1);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack, output logic [7:0] e);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit1(d[i], r);
            e[i] = r;
        end
        bit1(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit1(1'b1, r);
            d[i] = r;
        end
        bit1(~ack, r);
    endtask
endmodule // irs_master
`default_nettype wire

// *** sim/irs_slave_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module irs_slave_tb;
    logic       clk, rst_b;           // Core clock, reset
    logic       scl_m, sda_m;         // Master drives
    logic       scl_o, scl_oe_b;      // Slave clock drive
    logic       sda_o, sda_oe_b;      // Slave data drive
    logic       gc_en, busy;          // Slave status
    logic [7:0] page;                 // Selected page
    wire        scl_w, sda_w;         // Bus wires
    logic [7:0] mem [128];            // Page 0 model
    logic [7:0] pg;                   // Model page
    logic [6:0] ptr;                  // Model pointer
    int         n_mismatch, tests_run;
    // Open drain wires with pull-ups
    assign scl_w = scl_m & (scl_oe_b | scl_o);
    assign sda_w = sda_m & (sda_oe_b | sda_o);
    irs_slave i_dut (
        .clk      (clk),
        .rst_b    (rst_b),
        .scl_clk  (scl_w),
        .scl_i    (scl_w),
        .sda_i    (sda_w),
        .scl_o    (scl_o),
        .scl_oe_b (scl_oe_b),
        .sda_o    (sda_o),
        .sda_oe_b (sda_oe_b),
        .page     (page),
        .gc_en    (gc_en),
        .busy     (busy)
    );
    irs_master i_mst (
        .scl_m (scl_m),
        .sda_m (sda_m),
        .sda_w (sda_w)
    );
    // Core clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare and count
    task automatic check(input logic [7:0] s, input logic [7:0] x);
        tests_run++;
        if (s !== x) begin
            n_mismatch++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, s, x);
        end
    endtask
    // Expected read value at the pointer
    function automatic logic [7:0] exp_rd();
        if (ptr == 7'h00)
            return pg;
        return (pg == 8'h00) ? mem[ptr] : 8'h00;
    endfunction
    // Model of one register write
    task automatic mdl_wr(input logic [7:0] v);
        if (ptr == 7'h00)
            pg = v;
        else if (pg == 8'h00)
            mem[ptr] = v;
        ptr = ptr + 7'h01;
    endtask
    // Write n bytes at pointer p; first byte v, rest random
    task automatic xfer_wr(input logic [7:0] ab, input logic [6:0] p, input int n,
                           input logic [7:0] v);
        logic       a, ok;
        logic [7:0] e, dv;
        ok = (ab[7:1] == 7'h18) || (ab == 8'h00 && mem[34][5]);
        i_mst.start();
        check({7'h00, busy}, 8'h01);
        i_mst.wbyte(ab, a, e);
        check({7'h00, a}, {7'h00, ok});
        if (ok) begin
            i_mst.wbyte({1'b0, p}, a, e);
            check({7'h00, a}, 8'h01);
            ptr = p;
            for (int i = 0; i < n; i++) begin
                dv = (i == 0) ? v : 8'($urandom);
                i_mst.wbyte(dv, a, e);
                check({7'h00, a}, 8'h01);
                check(e, dv);
                mdl_wr(dv);
            end
        end
        i_mst.stop();
        check({6'h00, busy, sda_oe_b}, 8'h01);
        check({7'h00, gc_en}, {7'h00, mem[34][5]});
        check(page, pg);
    endtask
    // Set pointer p, repeated start, read n bytes
    task automatic xfer_rd(input logic [6:0] p, input int n);
        logic       a;
        logic [7:0] e, rv;
        i_mst.start();
        i_mst.wbyte(8'h30, a, e);
        i_mst.wbyte({1'b0, p}, a, e);
        ptr = p;
        i_mst.start();
        i_mst.wbyte(8'h31, a, e);
        check({6'h00, a, busy}, 8'h03);
        for (int i = 0; i < n; i++) begin
            i_mst.rbyte(i != n - 1, rv);
            check(rv, exp_rd());
            ptr = ptr + 7'h01;
        end
        i_mst.stop();
    endtask
    // Verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog, above the expected run length
    initial begin
        #700000;
        n_mismatch++;
        end_sim();
    end
    // Main sequence
    initial begin
        logic [6:0] a7;
        rst_b = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        pg = 8'h00;
        ptr = 7'h00;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(32'h46a0));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        check({4'h0, scl_oe_b, sda_oe_b, gc_en, busy}, 8'h0c);
        check(page, 8'h00);
        $display("test reset done");
        // Random writes, read back, pointer wrap
        for (int i = 0; i < 4; i++) begin
            a7 = 7'($urandom_range(1, 120));
            xfer_wr(8'h30, a7, 3, 8'($urandom));
            xfer_rd(a7, 3);
        end
        xfer_rd(7'h7e, 3);
        $display("test auto increment done");
        // Foreign addresses refused
        for (int i = 0; i < 3; i++) begin
            a7 = 7'($urandom);
            if (a7 == 7'h18 || a7 == 7'h00)
                a7 = a7 ^ 7'h40;
            xfer_wr({a7, 1'($urandom)}, 7'h01, 1, 8'h00);
        end
        $display("test address done");
        // General call disabled, then enabled
        xfer_wr(8'h30, 7'h22, 1, 8'h00);
        xfer_wr(8'h00, 7'h01, 1, 8'h00);
        xfer_wr(8'h30, 7'h22, 1, 8'h20);
        xfer_wr(8'h00, 7'h28, 2, 8'h5a);
        xfer_rd(7'h28, 2);
        xfer_wr(8'h30, 7'h22, 1, 8'h00);
        $display("test general call done");
        // Page select and unbacked page
        xfer_wr(8'h30, 7'h00, 1, 8'h01);
        xfer_wr(8'h30, 7'h05, 1, 8'ha5);
        xfer_rd(7'h00, 2);
        xfer_wr(8'h30, 7'h00, 1, 8'h00);
        xfer_rd(7'h05, 1);
        $display("test page done");
        // Slow master
        i_mst.hp = 12;
        xfer_wr(8'h30, 7'h40, 2, 8'hff);
        xfer_rd(7'h40, 2);
        i_mst.hp = 7;
        $display("test slow master done");
        end_sim();
    end
endmodule // irs_slave_tb
`default_nettype wire
